// file: core/ldc_top.sv
// dimming gate, early boost sequencing and pulse level duty conversion
`timescale 1ns/1ps
module ldc_top #(
    parameter int unsigned SHUT_CYC = ldc_pkg::SHUTDOWN_CYC,
    parameter int unsigned PTO_CYC = ldc_pkg::PULSE_TIMEOUT_CYC,
    parameter int unsigned PER_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic dim_in,
    input wire logic analog_level_input,
    input wire logic [15:0] early_boost_delay,
    output ldc_pkg::ldc_out_t ctl_q
);
    // ***************
    // input synchronisers
    // ***************
    logic [1:0] dim_s_q;
    logic [1:0] lvl_s_q;
    logic dim_d1_q;
    logic lvl_d1_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dim_s_q <= 2'h0;
            lvl_s_q <= 2'h0;
            dim_d1_q <= 1'b0;
            lvl_d1_q <= 1'b0;
        end else begin
            dim_s_q <= {dim_s_q[0], dim_in};
            lvl_s_q <= {lvl_s_q[0], analog_level_input};
            dim_d1_q <= dim_s_q[1];
            lvl_d1_q <= lvl_s_q[1];
        end
    end
    logic dim;
    logic dim_rise;
    logic lvl_rise;
    assign dim = dim_s_q[1];
    assign dim_rise = dim & ~dim_d1_q;
    assign lvl_rise = lvl_s_q[1] & ~lvl_d1_q;

    // ***************
    // shutdown timer
    // ***************
    logic [31:0] low_cnt_q;
    logic shut_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt_q <= 32'h0;
            shut_q <= 1'b1;
        end else if (dim) begin
            low_cnt_q <= 32'h0;
            shut_q <= 1'b0;
        end else if (low_cnt_q >= 32'(SHUT_CYC)) begin
            shut_q <= 1'b1;
        end else begin
            low_cnt_q <= low_cnt_q + 32'h1;
        end
    end

    // ***************
    // early boost sequencer
    // ***************
    ldc_pkg::ldc_state_t st_q;
    logic [15:0] dly_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ldc_pkg::LDC_OFF;
            dly_q <= 16'h0;
        end else begin
            case (st_q)
                ldc_pkg::LDC_OFF: begin
                    if (dim) begin
                        st_q <= ldc_pkg::LDC_PRE;
                        dly_q <= 16'h0;
                    end
                end
                ldc_pkg::LDC_PRE: begin
                    if (dly_q >= early_boost_delay) begin
                        st_q <= ldc_pkg::LDC_ON;
                        dly_q <= 16'h0;
                    end else begin
                        dly_q <= dly_q + 16'h1;
                    end
                end
                ldc_pkg::LDC_ON: begin
                    // held high stays here with no timeout
                    if (!dim) begin
                        st_q <= ldc_pkg::LDC_POST;
                        dly_q <= 16'h0;
                    end
                end
                ldc_pkg::LDC_POST: begin
                    // pulses are delayed, not shortened, so short on-times survive
                    if (dly_q >= early_boost_delay) begin
                        st_q <= dim ? ldc_pkg::LDC_PRE : ldc_pkg::LDC_OFF;
                        dly_q <= 16'h0;
                    end else begin
                        dly_q <= dly_q + 16'h1;
                    end
                end
                default: st_q <= ldc_pkg::LDC_OFF;
            endcase
        end
    end

    // ***************
    // pulse level mode detect and duty measure
    // ***************
    logic [PER_W-1:0] per_q;
    logic [PER_W-1:0] hi_q;
    logic [PER_W-1:0] pto_q;
    logic pmode_q;
    logic [15:0] filt_q;
    logic [7:0] duty;
    assign duty = (per_q == '0) ? 8'h0 : 8'(({8'h0, hi_q} * 24'(ldc_pkg::LEVEL_FULL)) / per_q);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            per_q <= '0;
            hi_q <= '0;
            pto_q <= '0;
            pmode_q <= 1'b0;
            filt_q <= {ldc_pkg::LEVEL_RST, 8'h0};
        end else begin
            if (lvl_rise) begin
                per_q <= '0;
                hi_q <= '0;
                pto_q <= '0;
                pmode_q <= 1'b1;
                if (pmode_q) begin
                    // first-order filter toward full minus duty
                    filt_q <= filt_q - (filt_q >> ldc_pkg::FILT_SHIFT)
                        + ({8'(ldc_pkg::LEVEL_FULL - duty), 8'h0} >> ldc_pkg::FILT_SHIFT);
                end
            end else begin
                if (per_q != '1) begin
                    per_q <= per_q + PER_W'(1);
                end
                if (lvl_s_q[1] && hi_q != '1) begin
                    hi_q <= hi_q + PER_W'(1);
                end
                if (pto_q >= PER_W'(PTO_CYC)) begin
                    pmode_q <= 1'b0;
                end else begin
                    pto_q <= pto_q + PER_W'(1);
                end
            end
        end
    end

    // ***************
    // outputs
    // ***************
    logic [7:0] lvl_raw;
    assign lvl_raw = pmode_q ? filt_q[15:8] : ldc_pkg::LEVEL_FULL;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_q <= '{boost_en: 1'b0, sink_en: 1'b0, pulse_level_mode: 1'b0,
                shutdown: 1'b1, peak_level: ldc_pkg::LEVEL_RST};
        end else begin
            ctl_q.boost_en <= (st_q != ldc_pkg::LDC_OFF) || dim_rise;
            ctl_q.sink_en <= (st_q == ldc_pkg::LDC_ON) || (st_q == ldc_pkg::LDC_POST);
            ctl_q.pulse_level_mode <= pmode_q;
            ctl_q.shutdown <= shut_q;
            ctl_q.peak_level <= (lvl_raw < ldc_pkg::LEVEL_MIN) ? ldc_pkg::LEVEL_MIN : lvl_raw;
        end
    end

    // ***************
    // checks
    // ***************
    chk_sink_needs_boost: assert property (@(posedge clk) disable iff (!rst_b)
        ctl_q.sink_en |-> ctl_q.boost_en) else $error("sinks on without boost");
    chk_level_floor: assert property (@(posedge clk) disable iff (!rst_b)
        ctl_q.peak_level >= ldc_pkg::LEVEL_MIN) else $error("peak level under floor");
    chk_pre_sinks_off: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == ldc_pkg::LDC_PRE |=> !ctl_q.sink_en) else $error("sinks on during early boost");
    chk_post_holds: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == ldc_pkg::LDC_POST |=> ctl_q.sink_en && ctl_q.boost_en) else $error("post hold lost");
    chk_on_follows: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == ldc_pkg::LDC_ON && dim |=> st_q == ldc_pkg::LDC_ON) else $error("left on while high");
    chk_mode_enter: assert property (@(posedge clk) disable iff (!rst_b)
        lvl_rise |=> pmode_q) else $error("pulse mode not entered");
    chk_full_in_volt: assert property (@(posedge clk) disable iff (!rst_b)
        !pmode_q |=> ctl_q.peak_level == ldc_pkg::LEVEL_FULL) else $error("voltage mode level");
    chk_wake_clears: assert property (@(posedge clk) disable iff (!rst_b)
        dim |=> !shut_q) else $error("shutdown held while high");

    // ***************
    // sequencing, timer and mode checks
    // ***************
    chk_boost_at_rise: assert property (@(posedge clk) disable iff (!rst_b)
        dim_rise |=> ctl_q.boost_en)
        else $error("boost late after rise");
    chk_pre_full_len: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == ldc_pkg::LDC_PRE && dly_q < early_boost_delay |=> st_q == ldc_pkg::LDC_PRE)
        else $error("early boost phase cut short");
    chk_fall_to_post: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == ldc_pkg::LDC_ON && !dim |=> st_q == ldc_pkg::LDC_POST)
        else $error("fall did not start hold");
    chk_post_full_len: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == ldc_pkg::LDC_POST && dly_q < early_boost_delay |=> st_q == ldc_pkg::LDC_POST)
        else $error("post hold cut short");
    chk_on_sinks_lit: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == ldc_pkg::LDC_ON |=> ctl_q.sink_en)
        else $error("sinks dark while on");
    chk_idle_dark: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == ldc_pkg::LDC_OFF && !dim_rise |=> !ctl_q.boost_en && !ctl_q.sink_en)
        else $error("outputs lit while idle");
    chk_shut_on_time: assert property (@(posedge clk) disable iff (!rst_b)
        !dim && low_cnt_q >= 32'(SHUT_CYC) |=> shut_q)
        else $error("shutdown missed after long low");
    chk_shut_not_early: assert property (@(posedge clk) disable iff (!rst_b)
        low_cnt_q < 32'(SHUT_CYC) && !shut_q |=> !shut_q)
        else $error("shutdown too early");
    chk_mode_timeout: assert property (@(posedge clk) disable iff (!rst_b)
        pmode_q && !lvl_rise && pto_q >= PER_W'(PTO_CYC) |=> !pmode_q)
        else $error("pulse mode not left on timeout");
    chk_mode_holds: assert property (@(posedge clk) disable iff (!rst_b)
        pmode_q && pto_q < PER_W'(PTO_CYC) |=> pmode_q)
        else $error("pulse mode left too early");
    chk_pulse_level: assert property (@(posedge clk) disable iff (!rst_b)
        pmode_q && filt_q[15:8] >= ldc_pkg::LEVEL_MIN |=> ctl_q.peak_level == $past(filt_q[15:8]))
        else $error("filtered level not applied");
endmodule // ldc_top

// file: core/ldc_pkg.sv
// constants and types of the led dimming control block
package ldc_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned PULSE_TIMEOUT_US = 50;
    localparam int unsigned PULSE_TIMEOUT_CYC = PULSE_TIMEOUT_US * CLK_MHZ;
    localparam int unsigned SHUTDOWN_MS = 16;
    localparam int unsigned SHUTDOWN_CYC = SHUTDOWN_MS * 1000 * CLK_MHZ;
    localparam int unsigned SETTLE_MS = 1;
    localparam int unsigned SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
    localparam int unsigned LEVEL_W = 8;
    localparam logic [7:0] LEVEL_FULL = 8'hff;
    localparam logic [7:0] LEVEL_MIN = 8'h1a;
    localparam logic [7:0] LEVEL_RST = 8'hff;
    localparam int unsigned FILT_SHIFT = 4;
    localparam int unsigned DELAY_W = 16;
    localparam logic [15:0] DELAY_RST = 16'h02ee;

    typedef enum logic [3:0] {
        LDC_OFF = 4'b0001,
        LDC_PRE = 4'b0010,
        LDC_ON = 4'b0100,
        LDC_POST = 4'b1000
    } ldc_state_t;

    typedef struct packed {
        logic boost_en;
        logic sink_en;
        logic pulse_level_mode;
        logic shutdown;
        logic [7:0] peak_level;
    } ldc_out_t;
endpackage

// file: test/ldc_host.sv
// host model that drives the pulse level clock pin
`timescale 1ns/1ps
module ldc_host (
    input wire logic clk,
    input wire logic run,
    input wire logic [15:0] per,
    input wire logic [15:0] hi,
    output logic analog_level_input
);
    logic [15:0] cnt_q;
    // bench keeps both phases >= 38 cycles and period within 40 khz to 1 mhz; low when idle
    always_ff @(posedge clk) begin
        cnt_q <= (!run || cnt_q >= per - 16'h1) ? 16'h0 : cnt_q + 16'h1;
        analog_level_input <= run && (cnt_q < hi);
    end
endmodule // ldc_host

// file: test/test_ldc_top.sv
// self-checking bench of the led dimming control block
`timescale 1ns/1ps
module test_ldc_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic dim_in = 1'b0;
    logic run = 1'b0;
    logic [15:0] per = 16'hfa;
    logic [15:0] hi = 16'h40;
    logic [15:0] dly = 16'h000a;
    logic level_pin;
    ldc_pkg::ldc_out_t ctl;
    int n_mismatch = 0;
    int n_checks = 0;
    always #2 clk = ~clk;
    ldc_host i_host (.clk(clk), .run(run), .per(per), .hi(hi), .analog_level_input(level_pin));
    // timeout sits above the longest pulse level period used here
    ldc_top #(.SHUT_CYC(200), .PTO_CYC(500)) i_dut (.clk(clk), .rst_b(rst_b),
        .dim_in(dim_in), .analog_level_input(level_pin), .early_boost_delay(dly), .ctl_q(ctl));
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic drv(input logic v);
        @(posedge clk);
        dim_in <= v;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_gate();
        int c;
        int t_b;
        c = 0;
        t_b = 0;
        drv(1'b1);
        while (!ctl.sink_en && c < 100) begin
            @(posedge clk);
            #1;
            c++;
            if (ctl.boost_en && t_b == 0) t_b = c;
        end
        // pre phase runs delay+1 cycles and the sink flop adds one more
        chk("sink_lag", 16'(c - t_b), dly + 16'h2);
        tick(5);
        drv(1'b0);
        c = 0;
        while (ctl.boost_en && c < 100) begin
            @(posedge clk);
            #1;
            c++;
            chk("fall_together", {15'h0, ctl.sink_en}, {15'h0, ctl.boost_en});
        end
        chk("hold_len", {15'h0, c >= int'(dly) && c < 100}, 16'h1);
        tick(300);
    endtask
    task automatic t_short();
        int n_on;
        n_on = 0;
        drv(1'b1);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            // 75 cycles of 4 ns make the shortest 300 ns pulse
            if (i == 74) dim_in <= 1'b0;
            #1;
            if (ctl.sink_en) n_on++;
        end
        chk("short_on", 16'(n_on), 16'h004b);
        tick(300);
    endtask
    task automatic t_long();
        drv(1'b1);
        tick(1000);
        #1;
        chk("full_on", {14'h0, ctl.sink_en, ctl.shutdown}, 16'h2);
        drv(1'b0);
        tick(260);
        #1;
        chk("sleep", {15'h0, ctl.shutdown}, 16'h1);
        chk("dark", {14'h0, ctl.boost_en, ctl.sink_en}, 16'h0);
    endtask
    task automatic t_level(input logic [15:0] p, input logic [15:0] h, input logic [7:0] lo_b,
        input logic [7:0] hi_b);
        @(posedge clk);
        per <= p;
        hi <= h;
        run <= 1'b1;
        tick(50);
        #1;
        chk("mode", {15'h0, ctl.pulse_level_mode}, 16'h1);
        // long enough for the filter to settle from the previous level
        tick(30000);
        #1;
        chk("level", {15'h0, ctl.peak_level >= lo_b && ctl.peak_level <= hi_b}, 16'h1);
    endtask
    task automatic t_drop();
        @(posedge clk);
        run <= 1'b0;
        tick(600);
        #1;
        chk("fallback", {7'h0, ctl.pulse_level_mode, ctl.peak_level}, 16'h00ff);
    endtask
    initial begin
        tick(6);
        rst_b <= 1'b1;
        tick(2);
        t_gate();
        t_short();
        t_long();
        t_level(16'h00fa, 16'h0040, 8'hae, 8'hce);
        // 38 low cycles keep the short phase at 152 ns
        t_level(16'h01c2, 16'h019c, 8'h1a, 8'h1a);
        t_drop();
        wrap_up();
    end
    initial begin
        #360000;
        n_mismatch++;
        wrap_up();
    end
endmodule // test_ldc_top
